/* File: logic/afc_consts.svh */
// Timing figures, encodings and limit values of the automatic fan speed controller.
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH
`define AFC_CLK_KHZ       10000
`define AFC_CLK_MHZ       10
`define AFC_UPDATE_MS     1000
`define AFC_HOLD_MS       1600
`define AFC_LOOP_MS       100
`define AFC_TACH_TICK_US  20
`define AFC_DUTY_FULL     8'hff
`define AFC_DUTY_OFF      8'h00
`define AFC_DUTY_RESET    8'hff
`define AFC_DUTY_STEP     8'h01
`define AFC_PWM_LAST      8'hfe
`define AFC_COUNT_STOP    12'hfff
`define AFC_COUNT_ZERO    12'h000
`define AFC_SLOPE_ONE     2'h0
`define AFC_SLOPE_HALF    2'h1
`define AFC_SLOPE_QUARTER 2'h2
`define AFC_SLOPE_ZERO    2'h3
`define AFC_LEVEL_FULL    3'h4
`define AFC_TEMP_HI       10'sh07f
`define AFC_TEMP_LO       10'sh380
`define AFC_SPEED_HI      11'sh0ff
`endif

/* File: logic/afc_fan_ctrl.sv */
// Temperature driven fan speed controller with PWM output and fan fault alarm.
`include "afc_consts.svh"
`default_nettype none
module afc_fan_ctrl import afc_pkg::*; #(
    parameter int NSRC          = 4,
    parameter int SELW          = 2,
    parameter int UPDATE_CYCLES = `AFC_UPDATE_MS * `AFC_CLK_KHZ,
    parameter int HOLD_CYCLES   = `AFC_HOLD_MS * `AFC_CLK_KHZ,
    parameter int LOOP_CYCLES   = `AFC_LOOP_MS * `AFC_CLK_KHZ
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire afc_mode_t            mode,
    input  wire logic                 auto_linear,
    input  wire logic                 auto_rpm_pct,
    input  wire afc_curve_t           curve,
    input  wire afc_scale_t           scale,
    input  wire logic [NSRC-1:0][7:0] temp_src,
    input  wire logic [SELW-1:0]      primary_sel,
    input  wire logic [SELW-1:0]      scale_sel,
    input  wire logic [7:0]           manual_duty,
    input  wire logic [11:0]          manual_expected,
    input  wire logic [11:0]          full_speed_count,
    input  wire logic [7:0]           min_duty,
    input  wire logic [7:0]           fault_period_sec,
    input  wire logic                 tach_pin,
    output var  logic                 pwm_output,
    output var  logic [7:0]           duty,
    output var  logic [11:0]          fan_count,
    output var  logic [11:0]          expected_count,
    output var  logic [7:0]           scaled_fan_temperature,
    output var  logic                 fan_fault_n
);
    logic [23:0]        sec_cnt_ff;
    logic [23:0]        loop_cnt_ff;
    logic [23:0]        hold_cnt_ff;
    logic               sec_tick;
    logic               loop_tick;
    logic signed [7:0]  primary_sensor_temperature;
    logic signed [7:0]  scaling_temperature;
    logic signed [9:0]  scale_diff;
    logic signed [9:0]  scale_adj;
    logic signed [9:0]  fan_temp_wide;
    logic signed [9:0]  fan_temp;
    logic [7:0]         scaled_temp_ff;
    logic [2:0]         raw_level;
    logic [2:0]         keep_level;
    logic [2:0]         level_ff;
    logic [2:0]         nxt_level;
    logic [1:0]         seg;
    logic signed [9:0]  seg_off;
    logic signed [9:0]  seg_span;
    logic signed [9:0]  seg_delta;
    logic signed [19:0] seg_prod;
    logic signed [19:0] seg_quot;
    logic signed [10:0] lin_sum;
    logic [7:0]         lin_speed;
    logic [7:0]         target_ff;
    logic [7:0]         nxt_target;
    logic [19:0]        pct_prod;
    logic [19:0]        pct_quot;
    logic [11:0]        pct_expected;
    logic [11:0]        expected_ff;
    logic [11:0]        nxt_expected;
    logic               closed_loop;
    logic               enter_hold;
    afc_loop_t          loop_ff;
    logic [7:0]         duty_ff;
    logic [7:0]         nxt_duty;
    logic [7:0]         pwm_cnt_ff;
    logic               pwm_out_ff;
    logic               slow;
    logic [7:0]         fault_sec_ff;
    logic               fault_n_ff;
    logic               fault_due;

    function automatic logic signed [9:0] afc_slope(input logic signed [9:0] d, input logic [1:0] code);
        unique case (code)
            `AFC_SLOPE_ONE:     afc_slope = d;
            `AFC_SLOPE_HALF:    afc_slope = d >>> 1;
            `AFC_SLOPE_QUARTER: afc_slope = d >>> 2;
            `AFC_SLOPE_ZERO:    afc_slope = 10'sh000;
        endcase
    endfunction

    afc_tach u_tach (
        .clk       (clk),
        .rstn      (rstn),
        .tach_pin  (tach_pin),
        .fan_count (fan_count)
    );

    // One-second update enable and the closed loop step enable.
    assign sec_tick  = (sec_cnt_ff == 24'(UPDATE_CYCLES - 1));
    assign loop_tick = (loop_cnt_ff == 24'(LOOP_CYCLES - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sec_cnt_ff <= 24'h000000;
        end else begin
            sec_cnt_ff <= sec_tick ? 24'h000000 : sec_cnt_ff + 24'h000001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loop_cnt_ff <= 24'h000000;
        end else begin
            loop_cnt_ff <= loop_tick ? 24'h000000 : loop_cnt_ff + 24'h000001;
        end
    end

    // Scaled fan temperature from the primary and the selected scaling source.
    assign primary_sensor_temperature = $signed(temp_src[primary_sel]);
    assign scaling_temperature        = $signed(temp_src[scale_sel]);
    assign scale_diff = 10'(scaling_temperature) - 10'($signed(scale.start_point));
    assign scale_adj  = (scale_diff >= 10'sh000) ? afc_slope(scale_diff, scale.slope_up)
                                                 : afc_slope(scale_diff, scale.slope_dn);
    assign fan_temp_wide = 10'(primary_sensor_temperature) + (scale.enable ? scale_adj : 10'sh000);

    always_comb begin
        if (fan_temp_wide > `AFC_TEMP_HI) begin
            fan_temp = `AFC_TEMP_HI;
        end else if (fan_temp_wide < `AFC_TEMP_LO) begin
            fan_temp = `AFC_TEMP_LO;
        end else begin
            fan_temp = fan_temp_wide;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scaled_temp_ff <= 8'h00;
        end else begin
            scaled_temp_ff <= fan_temp[7:0];
        end
    end

    // Interval position: raw_level counts boundaries exceeded, keep_level those still held within hysteresis.
    always_comb begin
        raw_level  = 3'h0;
        keep_level = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (fan_temp > 10'($signed(curve.boundary[i]))) begin
                raw_level = raw_level + 3'h1;
            end
            if (fan_temp >= 10'($signed(curve.boundary[i])) - $signed({6'h00, curve.hyst})) begin
                keep_level = keep_level + 3'h1;
            end
        end
    end

    always_comb begin
        if (raw_level > level_ff) begin
            nxt_level = raw_level;
        end else if (keep_level < level_ff) begin
            nxt_level = keep_level;
        end else begin
            nxt_level = level_ff;
        end
    end

    // Linear interpolation inside the segment that holds the fan temperature.
    assign seg       = (raw_level == 3'h0) ? 2'h0 : 2'(raw_level - 3'h1);
    assign seg_off   = fan_temp - 10'($signed(curve.boundary[seg]));
    assign seg_span  = 10'($signed(curve.boundary[2'(seg + 2'h1)])) - 10'($signed(curve.boundary[seg]));
    assign seg_delta = $signed({2'b00, curve.speed[2'(seg + 2'h1)]}) - $signed({2'b00, curve.speed[seg]});
    assign seg_prod  = 20'(seg_delta) * 20'(seg_off);
    assign seg_quot  = (seg_span > 10'sh000) ? seg_prod / 20'(seg_span) : 20'sh00000;
    assign lin_sum   = $signed({3'b000, curve.speed[seg]}) + seg_quot[10:0];

    always_comb begin
        if (raw_level == 3'h0) begin
            lin_speed = curve.speed[0];
        end else if (lin_sum > `AFC_SPEED_HI) begin
            lin_speed = `AFC_DUTY_FULL;
        end else if (lin_sum < 11'sh000) begin
            lin_speed = `AFC_DUTY_OFF;
        end else begin
            lin_speed = lin_sum[7:0];
        end
    end

    always_comb begin
        if (nxt_level == `AFC_LEVEL_FULL) begin
            nxt_target = `AFC_DUTY_FULL;
        end else if (auto_linear) begin
            nxt_target = lin_speed;
        end else begin
            nxt_target = curve.speed[nxt_level[1:0]];
        end
    end

    // The automatic target moves only on the one-second enable.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_ff  <= 3'h0;
            target_ff <= `AFC_DUTY_RESET;
        end else if (mode == AFC_AUTO && sec_tick) begin
            level_ff  <= nxt_level;
            target_ff <= nxt_target;
        end
    end

    // Percent of full speed becomes an expected count, which grows as the percentage falls.
    assign pct_prod = 20'(full_speed_count) * 20'(`AFC_DUTY_FULL);
    assign pct_quot = (target_ff == `AFC_DUTY_OFF) ? 20'(`AFC_COUNT_STOP) : pct_prod / 20'(target_ff);
    assign pct_expected = (pct_quot > 20'(`AFC_COUNT_STOP)) ? `AFC_COUNT_STOP : pct_quot[11:0];
    assign nxt_expected = (mode == AFC_MANUAL_RPM) ? manual_expected : pct_expected;
    assign closed_loop  = (mode == AFC_MANUAL_RPM) || (mode == AFC_AUTO && auto_rpm_pct);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            expected_ff <= `AFC_COUNT_ZERO;
        end else begin
            expected_ff <= nxt_expected;
        end
    end

    // Closed loop duty: forced values first, then the post-stop hold, then a single step per loop enable.
    assign slow       = fan_count > expected_ff;
    assign enter_hold = closed_loop && loop_ff == AFC_LOOP_RUN && loop_tick
                        && expected_ff != `AFC_COUNT_STOP && expected_ff != `AFC_COUNT_ZERO
                        && fan_count < expected_ff && min_duty != `AFC_DUTY_OFF && duty_ff == min_duty;

    always_comb begin
        nxt_duty = duty_ff;
        if (mode == AFC_MANUAL_DUTY) begin
            nxt_duty = manual_duty;
        end else if (!closed_loop) begin
            nxt_duty = target_ff;
        end else if (expected_ff == `AFC_COUNT_STOP) begin
            nxt_duty = `AFC_DUTY_OFF;
        end else if (expected_ff == `AFC_COUNT_ZERO) begin
            nxt_duty = `AFC_DUTY_FULL;
        end else if (loop_ff == AFC_LOOP_HOLD || enter_hold) begin
            nxt_duty = `AFC_DUTY_OFF;
        end else if (loop_tick) begin
            if (slow && duty_ff != `AFC_DUTY_FULL) begin
                nxt_duty = (duty_ff < min_duty) ? min_duty : duty_ff + `AFC_DUTY_STEP;
            end else if (fan_count < expected_ff && duty_ff != `AFC_DUTY_OFF) begin
                nxt_duty = duty_ff - `AFC_DUTY_STEP;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            duty_ff <= `AFC_DUTY_RESET;
        end else begin
            duty_ff <= nxt_duty;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loop_ff     <= AFC_LOOP_RUN;
            hold_cnt_ff <= 24'h000000;
        end else begin
            unique case (loop_ff)
                AFC_LOOP_RUN: begin
                    hold_cnt_ff <= 24'h000000;
                    if (enter_hold) begin
                        loop_ff <= AFC_LOOP_HOLD;
                    end
                end
                AFC_LOOP_HOLD: begin
                    hold_cnt_ff <= hold_cnt_ff + 24'h000001;
                    if (!closed_loop || hold_cnt_ff == 24'(HOLD_CYCLES - 1)) begin
                        loop_ff <= AFC_LOOP_RUN;
                    end
                end
            endcase
        end
    end

    // Fault timer counts seconds while the fan stays slower than expected.
    assign fault_due = (fault_sec_ff >= fault_period_sec);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_sec_ff <= 8'h00;
        end else if (!closed_loop || !slow || expected_ff == `AFC_COUNT_STOP) begin
            fault_sec_ff <= 8'h00;
        end else if (sec_tick && !fault_due) begin
            fault_sec_ff <= fault_sec_ff + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_n_ff <= 1'b1;
        end else begin
            fault_n_ff <= !(closed_loop && slow && expected_ff != `AFC_COUNT_STOP && fault_due
                            && (duty_ff == `AFC_DUTY_FULL
                                || (duty_ff > min_duty && fan_count == `AFC_COUNT_STOP)));
        end
    end

    // PWM period of 255 clocks so that duty 255 is always high and 0 always low.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwm_cnt_ff <= 8'h00;
            pwm_out_ff <= 1'b0;
        end else begin
            pwm_cnt_ff <= (pwm_cnt_ff == `AFC_PWM_LAST) ? 8'h00 : pwm_cnt_ff + 8'h01;
            pwm_out_ff <= pwm_cnt_ff < duty_ff;
        end
    end

    assign pwm_output             = pwm_out_ff;
    assign duty                   = duty_ff;
    assign expected_count         = expected_ff;
    assign scaled_fan_temperature = scaled_temp_ff;
    assign fan_fault_n            = fault_n_ff;
endmodule
`default_nettype wire

/* File: logic/afc_pkg.sv */
// Types shared by the automatic fan speed controller.
`default_nettype none
package afc_pkg;
    typedef enum logic [1:0] {AFC_MANUAL_DUTY, AFC_MANUAL_RPM, AFC_AUTO} afc_mode_t;
    typedef enum logic {AFC_LOOP_RUN, AFC_LOOP_HOLD} afc_loop_t;
    typedef struct packed {
        logic [3:0][7:0] boundary;
        logic [3:0][7:0] speed;
        logic [3:0]      hyst;
    } afc_curve_t;
    typedef struct packed {
        logic       enable;
        logic [7:0] start_point;
        logic [1:0] slope_up;
        logic [1:0] slope_dn;
    } afc_scale_t;
endpackage
`default_nettype wire

/* File: logic/afc_tach.sv */
// Tachometer period counter with pin synchroniser.
`include "afc_consts.svh"
`default_nettype none
module afc_tach import afc_pkg::*; #(
    parameter int TICK_CYCLES = `AFC_TACH_TICK_US * `AFC_CLK_MHZ
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        tach_pin,
    output var  logic [11:0] fan_count
);
    logic [2:0]  sync_ff;
    logic        tach_lvl_ff;
    logic [7:0]  tick_cnt_ff;
    logic [11:0] period_ff;
    logic [11:0] fan_count_ff;
    logic        tick;
    logic        rise;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // The line idles high under its pull-up, so reset matches it to avoid a false edge.
            sync_ff     <= 3'h7;
            tach_lvl_ff <= 1'b1;
        end else begin
            sync_ff <= {sync_ff[1:0], tach_pin};
            if (sync_ff[1] == sync_ff[2]) begin
                tach_lvl_ff <= sync_ff[2];
            end
        end
    end

    assign rise = (sync_ff[1] == sync_ff[2]) && sync_ff[2] && !tach_lvl_ff;
    assign tick = (tick_cnt_ff == 8'(TICK_CYCLES - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_ff <= 8'h00;
        end else begin
            tick_cnt_ff <= tick ? 8'h00 : tick_cnt_ff + 8'h01;
        end
    end

    // The count between two pulses is inversely proportional to speed; it sticks at all ones when pulses stop.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            period_ff    <= `AFC_COUNT_ZERO;
            fan_count_ff <= `AFC_COUNT_STOP;
        end else if (rise) begin
            period_ff    <= `AFC_COUNT_ZERO;
            fan_count_ff <= period_ff;
        end else if (tick) begin
            if (period_ff != `AFC_COUNT_STOP) begin
                period_ff <= period_ff + 12'h001;
            end else begin
                fan_count_ff <= `AFC_COUNT_STOP;
            end
        end
    end

    assign fan_count = fan_count_ff;
endmodule
`default_nettype wire

/* File: tb/afc_fan_ctrl_sva.sv */
// Property checker for the automatic fan speed controller, bound to its top module.
`default_nettype none
module afc_fan_ctrl_sva import afc_pkg::*; #(
    parameter int NSRC          = 4,
    parameter int SELW          = 2,
    parameter int UPDATE_CYCLES = 10000000
) (
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire afc_mode_t            mode,
    input wire logic                 auto_rpm_pct,
    input wire afc_scale_t           scale,
    input wire logic [NSRC-1:0][7:0] temp_src,
    input wire logic [SELW-1:0]      primary_sel,
    input wire logic [7:0]           manual_duty,
    input wire logic [7:0]           min_duty,
    input wire logic                 pwm_output,
    input wire logic [7:0]           duty,
    input wire logic [11:0]          fan_count,
    input wire logic [11:0]          expected_count,
    input wire logic [7:0]           scaled_fan_temperature,
    input wire logic                 fan_fault_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic fault_cond;
    logic open_auto;
    logic gap_arm_ff;
    int   gap_cnt_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    assign fault_cond = (duty == 8'hff) || ((duty > min_duty) && (fan_count == 12'hfff));
    assign open_auto  = (mode == AFC_AUTO) && !auto_rpm_pct;
    // Counts cycles since the last duty change while the open-loop target drives the duty.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_arm_ff <= 1'b0;
            gap_cnt_ff <= 0;
        end else if (!open_auto) begin
            gap_arm_ff <= 1'b0;
            gap_cnt_ff <= 0;
        end else if ($changed(duty)) begin
            // The change on entry to open-loop auto is not tick aligned, so it does not arm the check.
            gap_arm_ff <= $past(open_auto, 2);
            gap_cnt_ff <= 0;
        end else if (gap_cnt_ff < UPDATE_CYCLES) begin
            gap_cnt_ff <= gap_cnt_ff + 1;
        end
    end
    sequence s_force_off;
        (mode == AFC_MANUAL_RPM) && (expected_count == 12'hfff);
    endsequence
    sequence s_force_full;
        (mode == AFC_MANUAL_RPM) && (expected_count == 12'h000);
    endsequence
    reset_value_a: assert property ($rose(rstn) |-> duty == 8'hff && fan_count == 12'hfff)
        else $error("Duty or fan count not at reset value.");
    force_off_a: assert property (s_force_off ##1 s_force_off |-> duty == 8'h00)
        else $error("Duty not zero with stop count expected.");
    force_full_a: assert property (s_force_full ##1 s_force_full |-> duty == 8'hff)
        else $error("Duty not full with zero count expected.");
    pwm_off_a: assert property ((duty == 8'h00) [*3] |-> !pwm_output)
        else $error("PWM high at zero duty.");
    pwm_full_a: assert property ((duty == 8'hff) [*3] |-> pwm_output)
        else $error("PWM low at full duty.");
    manual_duty_a: assert property ((mode == AFC_MANUAL_DUTY && $stable(manual_duty) && rstn) [*2]
        |-> duty == manual_duty)
        else $error("Duty does not follow manual value.");
    fault_cause_a: assert property (!fan_fault_n && $past(rstn) |-> $past(fault_cond))
        else $error("Fan fault without full duty or stopped fan.");
    scale_pass_a: assert property (!scale.enable && $stable(scale) && $stable(temp_src) && $stable(primary_sel)
        && $past(rstn) |-> scaled_fan_temperature == temp_src[primary_sel])
        else $error("Fan temperature differs from primary sensor.");
    update_gap_a: assert property (open_auto && gap_arm_ff && $changed(duty)
        |-> gap_cnt_ff >= UPDATE_CYCLES - 1)
        else $error("Open-loop duty changed between updates.");
endmodule
bind afc_fan_ctrl afc_fan_ctrl_sva #(.NSRC(NSRC), .SELW(SELW), .UPDATE_CYCLES(UPDATE_CYCLES)) u_sva (
    .clk(clk), .rstn(rstn), .mode(mode), .auto_rpm_pct(auto_rpm_pct), .scale(scale), .temp_src(temp_src),
    .primary_sel(primary_sel), .manual_duty(manual_duty), .min_duty(min_duty), .pwm_output(pwm_output),
    .duty(duty), .fan_count(fan_count), .expected_count(expected_count),
    .scaled_fan_temperature(scaled_fan_temperature), .fan_fault_n(fan_fault_n)
);
`default_nettype wire

/* File: tb/afc_fan_model.sv */
// Behavioural fan that averages its PWM input per frame and pulses the tachometer faster at higher duty.
`default_nettype none
module afc_fan_model (
    input  wire logic clk,
    input  wire logic pwm_output,
    input  wire logic run_en,
    output var  logic tach_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] win_ff = 8'h00;
    logic [7:0] hi_ff  = 8'h00;
    logic [7:0] eff_ff = 8'h00;
    int         acc_ff = 0;
    initial tach_pin = 1'b1;
    always @(posedge clk) begin
        win_ff <= (win_ff == 8'hfe) ? 8'h00 : win_ff + 8'h01;
        hi_ff  <= (win_ff == 8'hfe) ? 8'h00 : hi_ff + 8'(pwm_output);
        if (win_ff == 8'hfe) begin
            eff_ff <= hi_ff + 8'(pwm_output);
        end
        // A stopped fan leaves the pulled-up tachometer line high.
        if (!run_en || eff_ff == 8'h00) begin
            tach_pin <= 1'b1;
            acc_ff   <= 0;
        end else if (acc_ff >= 25 * (300 - int'(eff_ff)) / 2) begin
            tach_pin <= ~tach_pin;
            acc_ff   <= 0;
        end else begin
            acc_ff <= acc_ff + 1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/auto_fan_speed_control_tb.sv */
// Self-checking testbench for the automatic fan speed controller.
`default_nettype none
`define AFC_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module auto_fan_speed_control_tb import afc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk, rstn, auto_linear, auto_rpm_pct, tach_pin, pwm_output, fan_fault_n, run_en;
    afc_mode_t       mode;
    afc_curve_t      curve;
    afc_scale_t      scale;
    logic [3:0][7:0] temp_src;
    logic [1:0]      primary_sel, scale_sel;
    logic [7:0]      manual_duty, min_duty, fault_period_sec, duty, scaled_fan_temperature, t;
    logic [11:0]     manual_expected, full_speed_count, fan_count, expected_count;
    int              error_cnt, comparisons, cycles, i, k, n, seed;
    logic [7:0]      tab_t[9] = '{8'd30, 8'd45, 8'd75, 8'd68, 8'd65, 8'd55, 8'd30, 8'd75, 8'd67};
    logic [7:0]      tab_e[9] = '{8'h50, 8'h64, 8'hff, 8'hff, 8'h8c, 8'h78, 8'h50, 8'hff, 8'hff};
    afc_fan_ctrl #(.UPDATE_CYCLES(100), .HOLD_CYCLES(160), .LOOP_CYCLES(10)) dut (
        .clk(clk), .rstn(rstn), .mode(mode), .auto_linear(auto_linear), .auto_rpm_pct(auto_rpm_pct),
        .curve(curve), .scale(scale), .temp_src(temp_src), .primary_sel(primary_sel), .scale_sel(scale_sel),
        .manual_duty(manual_duty), .manual_expected(manual_expected), .full_speed_count(full_speed_count),
        .min_duty(min_duty), .fault_period_sec(fault_period_sec), .tach_pin(tach_pin), .pwm_output(pwm_output),
        .duty(duty), .fan_count(fan_count), .expected_count(expected_count),
        .scaled_fan_temperature(scaled_fan_temperature), .fan_fault_n(fan_fault_n)
    );
    afc_fan_model fan (.clk(clk), .pwm_output(pwm_output), .run_en(run_en), .tach_pin(tach_pin));
    function automatic logic [7:0] lin_exp(input int tv);
        return 8'(80 + 2 * (tv - 40));
    endfunction
    function automatic logic [7:0] scl_exp(input int t1, input int d, input int code);
        return 8'(t1 + ((code == 3) ? 0 : (d >>> code)));
    endfunction
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic complete_run;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        seed = 32'hbe58a881;
        {clk, rstn, auto_linear, auto_rpm_pct, run_en, error_cnt, comparisons, cycles} = '0;
        mode = AFC_MANUAL_DUTY;
        curve = {32'h463c3228, 32'h8c786450, 4'h4};
        scale = '0;
        temp_src = '0;
        {primary_sel, scale_sel} = 4'h1;
        {manual_duty, min_duty, fault_period_sec} = {8'h80, 8'h40, 8'h0b};
        {manual_expected, full_speed_count} = {12'h014, 12'h100};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `AFC_CHK(duty, 8'hff)
        `AFC_CHK(fan_count, 12'hfff)
        `AFC_CHK(fan_fault_n, 1'b1)
        for (k = 0; k < 8; k++) begin
            @(posedge clk);
            manual_duty <= (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
            cyc(3);
            n = 0;
            repeat (255) begin @(negedge clk); n += int'(pwm_output); end
            `AFC_CHK(duty, manual_duty)
            `AFC_CHK(8'(n), manual_duty)
        end
        @(posedge clk);
        mode <= AFC_MANUAL_RPM;
        for (k = 0; k < 2; k++) begin
            manual_expected <= (k == 0) ? 12'hfff : 12'h000;
            cyc(4);
            @(negedge clk);
            `AFC_CHK(duty, (k == 0) ? 8'h00 : 8'hff)
            @(posedge clk);
        end
        manual_expected <= 12'h014;
        cyc(900);
        @(negedge clk);
        `AFC_CHK(fan_fault_n, 1'b1)
        for (i = 0; i < 3000 && fan_fault_n !== 1'b0; i++) @(negedge clk);
        `AFC_CHK(fan_fault_n, 1'b0)
        `AFC_CHK(duty, 8'hff)
        @(posedge clk);
        run_en <= 1'b1;
        for (i = 0; i < 8000 && fan_fault_n !== 1'b1; i++) @(negedge clk);
        cyc(500);
        @(negedge clk);
        `AFC_CHK(fan_fault_n, 1'b1)
        `AFC_CHK(duty < 8'hff, 1'b1)
        @(posedge clk);
        manual_expected <= 12'hffe;
        for (i = 0; i < 8000 && duty !== 8'h00; i++) @(negedge clk);
        @(posedge clk);
        manual_expected <= 12'h001;
        n = 0;
        repeat (140) begin @(negedge clk); n += int'(duty != 8'h00); end
        `AFC_CHK(n, 0)
        for (i = 0; i < 60 && duty === 8'h00; i++) @(negedge clk);
        `AFC_CHK(duty, min_duty)
        @(posedge clk);
        mode <= AFC_AUTO;
        for (k = 0; k < 13; k++) begin
            t = (k < 9) ? tab_t[k] : 8'(41 + $unsigned($random(seed)) % 19);
            @(posedge clk);
            auto_linear <= (k >= 6);
            temp_src[0] <= t;
            cyc(105);
            @(negedge clk);
            `AFC_CHK(duty, (k < 9) ? tab_e[k] : lin_exp(t))
        end
        @(posedge clk);
        auto_rpm_pct <= 1'b1;
        temp_src[0] <= 8'd30;
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            auto_linear <= 1'(k);
            cyc(105);
            @(negedge clk);
            `AFC_CHK(expected_count, 12'(256 * 255 / 80))
        end
        @(posedge clk);
        {auto_rpm_pct, auto_linear} <= 2'h1;
        temp_src[0] <= 8'd50;
        scale <= '{1'b1, 8'd40, 2'h0, 2'h0};
        for (k = 0; k < 8; k++) begin
            @(posedge clk);
            temp_src[1] <= (k < 4) ? 8'd48 : 8'd32;
            scale.slope_up <= 2'(k);
            scale.slope_dn <= 2'(k + 1);
            cyc(3);
            @(negedge clk);
            `AFC_CHK(scaled_fan_temperature, scl_exp(50, (k < 4) ? 8 : -8, (k < 4) ? k : (k + 1) % 4))
        end
        @(posedge clk);
        scale_sel <= 2'h0;
        temp_src[0] <= 8'd48;
        scale.slope_up <= 2'h0;
        cyc(105);
        @(negedge clk);
        `AFC_CHK(scaled_fan_temperature, scl_exp(48, 8, 0))
        `AFC_CHK(duty, lin_exp(56))
        complete_run();
    end
endmodule
`default_nettype wire
